// [src/afp_defines.vh]
/*
  register offsets, field positions, reset values and timing figures
  of the arc fault protection logic.
  assumes a 32-bit apb slave with byte addresses and a 20 mhz clock.
*/
`ifndef AFP_DEFINES_VH
`define AFP_DEFINES_VH

`define AFP_CLK_HZ 20000000
`define AFP_FORCE_TIMEOUT_S 300
`define AFP_LDLY_STEP_MS 10
`define AFP_LDLY_MIN 4'h1
`define AFP_LDLY_MAX 4'hf
`define AFP_FORCE_TIMEOUT_CYC 33'h1_65a0_bc00
`define AFP_LDLY_STEP_CYC 18'h3_0d40

`define AFP_OFS_CTRL 8'h00
`define AFP_OFS_SEL 8'h04
`define AFP_OFS_PICK0 8'h08
`define AFP_OFS_PICK1 8'h0c
`define AFP_OFS_PICK2 8'h10
`define AFP_OFS_LDLY 8'h14
`define AFP_OFS_STAT 8'h18
`define AFP_OFS_OMAP 8'h1c
`define AFP_OFS_LCNT 8'h20
`define AFP_OFS_SCNT0 8'h24
`define AFP_OFS_SCNT1 8'h28
`define AFP_OFS_SCNT2 8'h2c
`define AFP_OFS_TCNT0 8'h30
`define AFP_OFS_TCNT1 8'h34
`define AFP_OFS_TCNT2 8'h38
`define AFP_OFS_IRQ_STAT 8'h3c
`define AFP_OFS_IRQ_EN 8'h40
`define AFP_OFS_IRQ_CLR 8'h44
`define AFP_OFS_FLT_IDX 8'h48
`define AFP_OFS_FLT_TIME 8'h4c
`define AFP_OFS_FLT_VAL 8'h50
`define AFP_OFS_FLT_LOAD 8'h54
`define AFP_OFS_FLT_INFO 8'h58

`define AFP_CTRL_FORCE 0
`define AFP_SEL_DLY 12
`define AFP_STAT_TRIP 4
`define AFP_STAT_DLY 8
`define AFP_STAT_FORCE 12
`define AFP_IRQ_DLY 8
`define AFP_IRQ_FTO 9
`define AFP_INFO_ELAPSED_DELAY_PERCENT 8
`define AFP_INFO_TYPE 16

`define AFP_SEL_RST 16'h0000
`define AFP_PICK_RST 16'h0300
`define AFP_LDLY_RST 4'h1
`define AFP_OMAP_RST 9'h001
`define AFP_ELAPSED_DELAY_PERCENT_TRIP 8'h64

`endif

// [src/afp_top.v]
/*
  arc fault protection logic: three arc stages, delayed light signal,
  counters, force flag with timeout, fault log, apb register file.
  assumes current inputs are per-unit 8.8 values from logic on clk_in,
  light and dry inputs are raw pins, and a time stamp arrives on clk_in.
*/
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "afp_defines.vh"

// Notes on behaviour
// R1 - three stages: phase, earth one, earth two
// R2 - eight source codes, none disables stage
// R3 - combined selection ORs chosen light sources
// R4 - light alone gives start status
// R5 - light plus overcurrent gives trip
// R6 - phase stage uses largest phase current
// R7 - pickups per-unit of each input's rating
// R8 - delayed light, own selection, 10-150 ms
// R9 - clearable counter of any light
// R10 - per-stage light counter and clearable trips
// R11 - common force flag, clears after five minutes
// R12 - status writable under force; counters clearable
// R13 - operator gives password before setting changes; this logic checks no password, software does
// R14 - dry input routed out to matrix
// R15 - wetted output driven by its selection
// R16 - log eight latest faults with stamps
// R17 - type and load logged for phase only
// R18 - elapsed delay percent, 100 means trip
module afp_top #(
  parameter [32:0] FORCE_TIMEOUT_CYC = `AFP_FORCE_TIMEOUT_CYC,
  parameter [17:0] LDLY_STEP_CYC = `AFP_LDLY_STEP_CYC
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  input wire light_sensor_one_in,
  input wire light_sensor_two_in,
  input wire arc_card_dry_input_in,
  input wire [15:0] phase_a_current_in,
  input wire [15:0] phase_b_current_in,
  input wire [15:0] phase_c_current_in,
  input wire [15:0] earth_one_current_in,
  input wire [15:0] earth_two_current_in,
  input wire [31:0] timestamp_in,
  output reg [2:0] stage_start_out,
  output reg [2:0] stage_trip_out,
  output reg delayed_light_out,
  output reg dry_input_route_out,
  output reg arc_card_wetted_output_out,
  output reg irq_out
);

////////////////////////////////////////////////////////////////////////
// pin synchronisers
reg [2:0] pin_meta, pin_sync;
always @(posedge clk_in) begin
  if (sys_rst_in) begin
    pin_meta <= 3'h0;
    pin_sync <= 3'h0;
  end else begin
    pin_meta <= {arc_card_dry_input_in, light_sensor_two_in,
                 light_sensor_one_in};
    pin_sync <= pin_meta;
  end
end

////////////////////////////////////////////////////////////////////////
// apb access decode
reg force_flag;
reg [15:0] src_sel;
reg [15:0] pickup [0:2];
reg [3:0] ldly_set;
reg [8:0] omap;
reg [15:0] light_cnt;
reg [15:0] start_cnt [0:2], trip_cnt [0:2];
reg [9:0] irq_stat;
reg [9:0] irq_en;
reg [2:0] flt_idx;
reg [2:0] forced_start, forced_trip;
wire acc = psel_in & penable_in & pready_out;
wire wr = acc & pwrite_in;
wire [7:0] a = paddr_in;
reg known;

always @* begin
  case (a)
    `AFP_OFS_CTRL, `AFP_OFS_SEL, `AFP_OFS_PICK0, `AFP_OFS_PICK1,
    `AFP_OFS_PICK2, `AFP_OFS_LDLY, `AFP_OFS_STAT, `AFP_OFS_OMAP,
    `AFP_OFS_LCNT, `AFP_OFS_SCNT0, `AFP_OFS_SCNT1, `AFP_OFS_SCNT2,
    `AFP_OFS_TCNT0, `AFP_OFS_TCNT1, `AFP_OFS_TCNT2,
    `AFP_OFS_IRQ_STAT, `AFP_OFS_IRQ_EN, `AFP_OFS_IRQ_CLR,
    `AFP_OFS_FLT_IDX, `AFP_OFS_FLT_TIME, `AFP_OFS_FLT_VAL,
    `AFP_OFS_FLT_LOAD, `AFP_OFS_FLT_INFO: known = 1'b1;
    default: known = 1'b0;
  endcase
end

////////////////////////////////////////////////////////////////////////
// light sources and stage decisions
wire [15:0] max_ab = (phase_a_current_in > phase_b_current_in) ?
  phase_a_current_in : phase_b_current_in;
wire [15:0] largest_phase_current = (max_ab > phase_c_current_in) ?
  max_ab : phase_c_current_in; // R6
wire [15:0] stage_current [0:2];
assign stage_current[0] = largest_phase_current; // R6
assign stage_current[1] = earth_one_current_in; // R1
assign stage_current[2] = earth_two_current_in; // R1

// code bits are sensor one, sensor two, dry input; zero selects nothing
wire [2:0] stage_light;
wire [2:0] live_trip;
genvar g;
generate
  for (g = 0; g < 3; g = g + 1) begin : stg
    assign stage_light[g] = |(src_sel[4*g +: 3] & pin_sync); // R2 R3
    // pickup and current share the per-unit scale of their own input
    assign live_trip[g] = stage_light[g] &
      (stage_current[g] > pickup[g]); // R5 R7
  end
endgenerate
wire dly_light = |(src_sel[`AFP_SEL_DLY +: 3] & pin_sync); // R8
wire any_light = |pin_sync; // R9

wire [2:0] eff_start = force_flag ? forced_start : stage_light; // R4 R12
wire [2:0] eff_trip = force_flag ? forced_trip : live_trip; // R12
reg [2:0] prev_start, prev_trip;
reg prev_light, prev_dly;
wire [2:0] start_rise = eff_start & ~prev_start;
wire [2:0] trip_rise = eff_trip & ~prev_trip;

////////////////////////////////////////////////////////////////////////
// delayed light: step ticks counted while light persists
reg [17:0] step_cnt;
reg [3:0] step_num;
wire [3:0] ldly_lim = (ldly_set < `AFP_LDLY_MIN) ? `AFP_LDLY_MIN :
  ldly_set;
always @(posedge clk_in) begin
  if (sys_rst_in || !dly_light) begin
    step_cnt <= 18'h0_0000;
    step_num <= 4'h0;
  end else if (step_num != ldly_lim) begin
    if (step_cnt == LDLY_STEP_CYC - 18'h0_0001) begin
      step_cnt <= 18'h0_0000;
      step_num <= step_num + 4'h1; // R8
    end else begin
      step_cnt <= step_cnt + 18'h0_0001;
    end
  end
end
wire dly_now = dly_light && (step_num == ldly_lim);

////////////////////////////////////////////////////////////////////////
// force flag with timeout
reg [32:0] force_cnt;
wire force_to = force_flag && (force_cnt == FORCE_TIMEOUT_CYC - 33'h1);
always @(posedge clk_in) begin
  if (sys_rst_in) begin
    force_flag <= 1'b0;
    force_cnt <= 33'h0;
  end else if (force_to) begin
    force_flag <= 1'b0; // R11
    force_cnt <= 33'h0;
  end else if (wr && a == `AFP_OFS_CTRL) begin
    force_flag <= pwdata_in[`AFP_CTRL_FORCE]; // R11
    force_cnt <= 33'h0;
  end else if (force_flag) begin
    force_cnt <= force_cnt + 33'h1;
  end
end

////////////////////////////////////////////////////////////////////////
// settings and forced status; password check lives in software (R13)
always @(posedge clk_in) begin
  if (sys_rst_in) begin
    src_sel <= `AFP_SEL_RST;
    pickup[0] <= `AFP_PICK_RST;
    pickup[1] <= `AFP_PICK_RST;
    pickup[2] <= `AFP_PICK_RST;
    ldly_set <= `AFP_LDLY_RST;
    omap <= `AFP_OMAP_RST;
    irq_en <= 10'h000;
    flt_idx <= 3'h0;
    forced_start <= 3'h0;
    forced_trip <= 3'h0;
  end else begin
    if (wr) begin
      case (a)
        `AFP_OFS_SEL: src_sel <= pwdata_in[15:0];
        `AFP_OFS_PICK0: pickup[0] <= pwdata_in[15:0];
        `AFP_OFS_PICK1: pickup[1] <= pwdata_in[15:0];
        `AFP_OFS_PICK2: pickup[2] <= pwdata_in[15:0];
        `AFP_OFS_LDLY: ldly_set <= (pwdata_in[3:0] > `AFP_LDLY_MAX) ?
          `AFP_LDLY_MAX : pwdata_in[3:0];
        `AFP_OFS_OMAP: omap <= pwdata_in[8:0];
        `AFP_OFS_IRQ_EN: irq_en <= pwdata_in[9:0];
        `AFP_OFS_FLT_IDX: flt_idx <= pwdata_in[2:0];
        default: ;
      endcase
    end
    if (!force_flag) begin
      // forced values start from the live state when force is raised
      forced_start <= stage_light;
      forced_trip <= live_trip;
    end else if (wr && a == `AFP_OFS_STAT) begin
      forced_start <= pwdata_in[2:0]; // R12
      forced_trip <= pwdata_in[`AFP_STAT_TRIP +: 3]; // R12
    end
  end
end

////////////////////////////////////////////////////////////////////////
// counters and interrupt status
integer i;
always @(posedge clk_in) begin
  if (sys_rst_in) begin
    prev_start <= 3'h0;
    prev_trip <= 3'h0;
    prev_light <= 1'b0;
    prev_dly <= 1'b0;
    light_cnt <= 16'h0000;
    irq_stat <= 10'h000;
    for (i = 0; i < 3; i = i + 1) begin
      start_cnt[i] <= 16'h0000;
      trip_cnt[i] <= 16'h0000;
    end
  end else begin
    prev_start <= eff_start;
    prev_trip <= eff_trip;
    prev_light <= any_light;
    prev_dly <= dly_now;
    // a clear write loses to an increment in the same cycle
    if (any_light && !prev_light)
      light_cnt <= light_cnt + 16'h0001; // R9
    else if (wr && a == `AFP_OFS_LCNT)
      light_cnt <= 16'h0000; // R9
    for (i = 0; i < 3; i = i + 1) begin
      if (start_rise[i])
        start_cnt[i] <= start_cnt[i] + 16'h0001; // R10
      else if (wr && a == `AFP_OFS_SCNT0 + 4 * i)
        start_cnt[i] <= 16'h0000; // R12
      if (trip_rise[i])
        trip_cnt[i] <= trip_cnt[i] + 16'h0001; // R10
      else if (wr && a == `AFP_OFS_TCNT0 + 4 * i)
        trip_cnt[i] <= 16'h0000; // R12
    end
    irq_stat <= (irq_stat & ~((wr && a == `AFP_OFS_IRQ_CLR) ?
      pwdata_in[9:0] : 10'h000)) |
      {force_to, dly_now & ~prev_dly, 1'b0, trip_rise, 1'b0, start_rise};
  end
end

////////////////////////////////////////////////////////////////////////
// fault log: eight entries, written when a fault ends
reg [31:0] log_time [0:7];
reg [15:0] log_val [0:7];
reg [15:0] log_load [0:7];
reg [1:0] log_stage [0:7];
reg [7:0] log_elapsed_delay_percent [0:7];
reg [2:0] log_type [0:7];
reg [2:0] log_wp;
reg in_fault;
reg [1:0] f_stage;
reg [31:0] f_time;
reg [15:0] f_val, f_load, pre_load;
integer j;
reg f_trip;
reg [2:0] f_type;
wire [1:0] first_stage = start_rise[0] ? 2'd0 :
  (start_rise[1] ? 2'd1 : 2'd2);
wire [2:0] over_ph = {phase_c_current_in > pickup[0],
  phase_b_current_in > pickup[0], phase_a_current_in > pickup[0]};
always @(posedge clk_in) begin
  if (sys_rst_in) begin
    log_wp <= 3'h0;
    in_fault <= 1'b0;
    f_stage <= 2'd0;
    f_time <= 32'h0000_0000;
    f_val <= 16'h0000;
    f_load <= 16'h0000;
    pre_load <= 16'h0000;
    f_trip <= 1'b0;
    f_type <= 3'h0;
    for (j = 0; j < 8; j = j + 1) begin
      log_time[j] <= 32'h0000_0000;
      log_val[j] <= 16'h0000;
      log_load[j] <= 16'h0000;
      log_stage[j] <= 2'd0;
      log_elapsed_delay_percent[j] <= 8'h00;
      log_type[j] <= 3'h0;
    end
  end else if (!in_fault) begin
    pre_load <= largest_phase_current;
    if (|start_rise) begin
      in_fault <= 1'b1;
      f_stage <= first_stage;
      f_time <= timestamp_in; // R16
      f_val <= stage_current[first_stage];
      f_load <= pre_load; // R17
      f_trip <= 1'b0;
      f_type <= 3'h0;
    end
  end else begin
    if (stage_current[f_stage] > f_val)
      f_val <= stage_current[f_stage];
    if (eff_trip[f_stage])
      f_trip <= 1'b1;
    if (f_stage == 2'd0)
      f_type <= f_type | (over_ph & {3{stage_light[0]}}); // R17
    if (!eff_start[f_stage]) begin
      in_fault <= 1'b0;
      log_wp <= log_wp + 3'h1; // R16
      log_time[log_wp] <= f_time;
      log_val[log_wp] <= f_val;
      log_load[log_wp] <= (f_stage == 2'd0) ? f_load : 16'h0000; // R17
      log_type[log_wp] <= (f_stage == 2'd0) ? f_type : 3'h0; // R17
      log_stage[log_wp] <= f_stage;
      // arc stages have no delay: elapsed is all or nothing
      log_elapsed_delay_percent[log_wp] <= f_trip ? `AFP_ELAPSED_DELAY_PERCENT_TRIP : 8'h00; // R18
    end
  end
end
// index 0 reads the newest entry
wire [2:0] rd_slot = log_wp - 3'h1 - flt_idx;

////////////////////////////////////////////////////////////////////////
// read mux
reg [31:0] rd;
always @* begin
  rd = 32'h0000_0000;
  case (a)
    `AFP_OFS_CTRL: rd = {31'h0, force_flag};
    `AFP_OFS_SEL: rd = {16'h0000, src_sel};
    `AFP_OFS_PICK0: rd = {16'h0000, pickup[0]};
    `AFP_OFS_PICK1: rd = {16'h0000, pickup[1]};
    `AFP_OFS_PICK2: rd = {16'h0000, pickup[2]};
    `AFP_OFS_LDLY: rd = {28'h0, ldly_set};
    `AFP_OFS_STAT: rd = {19'h0, force_flag, 3'h0, delayed_light_out,
      1'b0, stage_trip_out, 1'b0, stage_start_out};
    `AFP_OFS_OMAP: rd = {23'h0, omap};
    `AFP_OFS_LCNT: rd = {16'h0000, light_cnt};
    `AFP_OFS_SCNT0: rd = {16'h0000, start_cnt[0]};
    `AFP_OFS_SCNT1: rd = {16'h0000, start_cnt[1]};
    `AFP_OFS_SCNT2: rd = {16'h0000, start_cnt[2]};
    `AFP_OFS_TCNT0: rd = {16'h0000, trip_cnt[0]};
    `AFP_OFS_TCNT1: rd = {16'h0000, trip_cnt[1]};
    `AFP_OFS_TCNT2: rd = {16'h0000, trip_cnt[2]};
    `AFP_OFS_IRQ_STAT: rd = {22'h0, irq_stat};
    `AFP_OFS_IRQ_EN: rd = {22'h0, irq_en};
    `AFP_OFS_FLT_IDX: rd = {29'h0, flt_idx};
    `AFP_OFS_FLT_TIME: rd = log_time[rd_slot];
    `AFP_OFS_FLT_VAL: rd = {16'h0000, log_val[rd_slot]};
    `AFP_OFS_FLT_LOAD: rd = {16'h0000, log_load[rd_slot]};
    `AFP_OFS_FLT_INFO: rd = {13'h0, log_type[rd_slot], log_elapsed_delay_percent[rd_slot],
      6'h0, log_stage[rd_slot]};
    default: rd = 32'h0000_0000;
  endcase
end

////////////////////////////////////////////////////////////////////////
// apb answer and registered outputs
always @(posedge clk_in) begin
  if (sys_rst_in) begin
    pready_out <= 1'b0;
    prdata_out <= 32'h0000_0000;
    pslverr_out <= 1'b0;
    stage_start_out <= 3'h0;
    stage_trip_out <= 3'h0;
    delayed_light_out <= 1'b0;
    dry_input_route_out <= 1'b0;
    arc_card_wetted_output_out <= 1'b0;
    irq_out <= 1'b0;
  end else begin
    // one wait state: pready rises in the second access cycle
    pready_out <= psel_in & penable_in & ~pready_out;
    prdata_out <= (psel_in & penable_in & ~pready_out & ~pwrite_in) ?
      rd : 32'h0000_0000;
    pslverr_out <= psel_in & penable_in & ~pready_out & ~known;
    stage_start_out <= eff_start; // R4
    stage_trip_out <= eff_trip; // R5
    delayed_light_out <= dly_now; // R8
    dry_input_route_out <= pin_sync[2]; // R14
    arc_card_wetted_output_out <= |(omap & {eff_start, eff_trip,
      pin_sync[2], any_light, dly_now}); // R15
    irq_out <= |(irq_stat & irq_en);
  end
end

endmodule

// [testbench/afp_top_asserts.sv]
/*
  checker on the afp_top ports: apb handshake, stage outputs, routing.
  assumes a single clock domain and a synchronous reset.
*/
`timescale 1ns/100ps
module afp_top_asserts (
  input wire clk_in,
  input wire sys_rst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  input wire light_sensor_one_in,
  input wire light_sensor_two_in,
  input wire arc_card_dry_input_in,
  input wire [2:0] stage_start_out,
  input wire [2:0] stage_trip_out,
  input wire delayed_light_out,
  input wire dry_input_route_out
);
  wire any_light;
  reg forced;
  reg [3:0] dark_cnt;
  assign any_light = light_sensor_one_in | light_sensor_two_in |
    arc_card_dry_input_in;
  // forced status may show anything, so stage checks stop once seen
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      forced <= 1'b0;
      dark_cnt <= 4'h0;
    end else begin
      if (psel_in && penable_in && pready_out && pwrite_in &&
          paddr_in == 8'h00 && pwdata_in[0]) begin
        forced <= 1'b1;
      end
      dark_cnt <= any_light ? 4'h0 : dark_cnt + {3'h0, dark_cnt != 4'hf};
    end
  end
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  //////////////////////////////////////////////////////////////////////
  pready_wait_a: assert property (
    psel_in && penable_in && !pready_out |=> pready_out)
    else $error("ready missing after one wait state");
  pready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  slverr_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h0000_0000)
    else $error("read data outside ready");
  trip_start_a: assert property (
    !forced |-> (stage_trip_out & ~stage_start_out) == 3'h0)
    else $error("trip without start");
  start_light_a: assert property (
    !forced && stage_start_out != 3'h0 |-> dark_cnt < 4'h6)
    else $error("start without light");
  route_dry_a: assert property (
    $rose(arc_card_dry_input_in) |-> ##[1:4] dry_input_route_out)
    else $error("dry input not routed");
  dly_off_a: assert property (dark_cnt > 4'h5 |-> !delayed_light_out)
    else $error("delayed light without light");
  cover property (stage_trip_out != 3'h0);
  cover property ($rose(delayed_light_out));
  cover property (pslverr_out);
endmodule
bind afp_top afp_top_asserts u_chk (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .light_sensor_one_in(light_sensor_one_in),
  .light_sensor_two_in(light_sensor_two_in),
  .arc_card_dry_input_in(arc_card_dry_input_in),
  .stage_start_out(stage_start_out), .stage_trip_out(stage_trip_out),
  .delayed_light_out(delayed_light_out),
  .dry_input_route_out(dry_input_route_out)
);

// [testbench/afp_field.sv]
/*
  field model: light sensors, dry input and the five current inputs.
  assumes the bench changes its requests right after a clock edge.
*/
`timescale 1ns/100ps
module afp_field (
  input wire [2:0] light_req_in,
  input wire [15:0] cur_req_in,
  input wire [1:0] big_sel_in,
  output logic [2:0] pins_out,
  output logic [15:0] cur_a_out,
  output logic [15:0] cur_b_out,
  output logic [15:0] cur_c_out,
  output logic [15:0] cur_e_out
);
  // one phase carries the fault, the others sit at rated load
  always @* begin
    pins_out = light_req_in;
    cur_a_out = (big_sel_in == 2'h0) ? cur_req_in : 16'h0100;
    cur_b_out = (big_sel_in == 2'h1) ? cur_req_in : 16'h0100;
    cur_c_out = (big_sel_in == 2'h2) ? cur_req_in : 16'h0100;
    cur_e_out = cur_req_in;
  end
endmodule

// [testbench/afp_top_tb.sv]
/*
  self-checking bench for afp_top driven by the field model.
  assumes a sim-sized delay step and force timeout.
*/
`timescale 1ns/100ps
module afp_top_tb;
  typedef struct packed {
    logic [2:0] code;
    logic [2:0] pins;
    logic [15:0] cur;
    logic [2:0] st;
    logic [2:0] tr;
  } afp_row_t;
  reg clk_in = 1'b0;
  reg sys_rst_in = 1'b1;
  reg psel_in = 1'b0;
  reg penable_in = 1'b0;
  reg pwrite_in = 1'b0;
  reg [7:0] paddr_in = 8'h00;
  reg [31:0] pwdata_in = 32'h0000_0000;
  reg [2:0] light_req = 3'h0;
  reg [15:0] cur_req = 16'h0000;
  reg [1:0] big_sel = 2'h0;
  wire [31:0] prdata_out;
  wire pready_out, pslverr_out, dly, route, wet, irq;
  wire [2:0] pins, start, trip;
  wire [15:0] cur_a, cur_b, cur_c, cur_e;
  logic [31:0] rd;
  logic err;
  int err_total = 0;
  int checked = 0;
  afp_row_t rows [10] = '{'{3'h0, 3'h7, 16'h0400, 3'h0, 3'h0},
    '{3'h1, 3'h1, 16'h0400, 3'h7, 3'h7}, '{3'h1, 3'h6, 16'h0400, 3'h0, 3'h0},
    '{3'h2, 3'h2, 16'h0300, 3'h7, 3'h0}, '{3'h3, 3'h4, 16'h0400, 3'h0, 3'h0},
    '{3'h3, 3'h2, 16'h0301, 3'h7, 3'h7}, '{3'h4, 3'h4, 16'h0200, 3'h7, 3'h0},
    '{3'h5, 3'h4, 16'h0400, 3'h7, 3'h7}, '{3'h6, 3'h1, 16'h0400, 3'h0, 3'h0},
    '{3'h7, 3'h2, 16'h0400, 3'h7, 3'h7}};
  logic [39:0] rvals [6] = '{{8'h04, 32'h0}, {8'h08, 32'h0300},
    {8'h10, 32'h0300}, {8'h14, 32'h1}, {8'h1c, 32'h1}, {8'h20, 32'h0}};
  afp_top #(.FORCE_TIMEOUT_CYC(33'd200), .LDLY_STEP_CYC(18'd10)) dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .light_sensor_one_in(pins[0]),
    .light_sensor_two_in(pins[1]), .arc_card_dry_input_in(pins[2]),
    .phase_a_current_in(cur_a), .phase_b_current_in(cur_b),
    .phase_c_current_in(cur_c), .earth_one_current_in(cur_e),
    .earth_two_current_in(cur_e), .timestamp_in(32'h1234_5678),
    .stage_start_out(start), .stage_trip_out(trip),
    .delayed_light_out(dly), .dry_input_route_out(route),
    .arc_card_wetted_output_out(wet), .irq_out(irq));
  afp_field field (.light_req_in(light_req), .cur_req_in(cur_req),
    .big_sel_in(big_sel), .pins_out(pins), .cur_a_out(cur_a),
    .cur_b_out(cur_b), .cur_c_out(cur_c), .cur_e_out(cur_e));
  always #25 clk_in = ~clk_in;
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic rdc(input string name, input logic [7:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(name, rd, e);
  endtask
  task automatic set(input logic [2:0] l, logic [15:0] c, logic [1:0] b);
    @(posedge clk_in);
    light_req <= l;
    cur_req <= c;
    big_sel <= b;
    tick(6);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    err_total++;
    finish_test;
  end
  initial begin
    tick(4);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, 8'h04, {16'h0, {4{1'b0, rows[i].code}}});
      set(rows[i].pins, rows[i].cur, 2'(i % 3));
      chk("start", start, rows[i].st);
      chk("trip", trip, rows[i].tr);
      chk("route", route, rows[i].pins[2]);
    end
    $display("test table done");
    sys_rst_in <= 1'b1;
    tick(4);
    chk("rst_start", start, 3'h0);
    chk("rst_trip", trip, 3'h0);
    sys_rst_in <= 1'b0;
    light_req <= 3'h0;
    for (int i = 0; i < 6; i++) rdc("reset", rvals[i][39:32], rvals[i][31:0]);
    $display("test reset done");
    apb(1'b1, 8'h04, 32'h0000_0777);
    set(3'h0, 16'h0400, 2'h1);
    set(3'h1, 16'h0400, 2'h1);
    set(3'h0, 16'h0400, 2'h1);
    rdc("lcnt", 8'h20, 32'h1);
    rdc("scnt", 8'h2c, 32'h1);
    rdc("tcnt", 8'h30, 32'h1);
    apb(1'b1, 8'h30, 32'h0);
    rdc("tclr", 8'h30, 32'h0);
    rdc("ftime", 8'h4c, 32'h1234_5678);
    rdc("fval", 8'h50, 32'h0400);
    rdc("fload", 8'h54, 32'h0400);
    rdc("finfo", 8'h58, 32'h0002_6400);
    apb(1'b1, 8'h10, 32'h0500);
    set(3'h1, 16'h0400, 2'h2);
    chk("pickup", trip, 3'h3);
    $display("test counters done");
    apb(1'b1, 8'h14, 32'h1f);
    rdc("ldly", 8'h14, 32'hf);
    apb(1'b1, 8'h14, 32'h2);
    apb(1'b1, 8'h04, 32'h2000);
    set(3'h0, 16'h0, 2'h0);
    apb(1'b1, 8'h44, 32'hffff_ffff);
    apb(1'b1, 8'h40, 32'h0100);
    set(3'h2, 16'h0, 2'h0);
    tick(10);
    chk("dly_early", dly, 1'b0);
    tick(12);
    chk("dly", dly, 1'b1);
    chk("wet", wet, 1'b1);
    chk("irq", irq, 1'b1);
    apb(1'b1, 8'h40, 32'h0);
    tick(2);
    chk("irq_mask", irq, 1'b0);
    apb(1'b1, 8'h40, 32'h0100);
    tick(2);
    chk("irq_on", irq, 1'b1);
    apb(1'b1, 8'h44, 32'h0100);
    tick(2);
    chk("irq_clr", irq, 1'b0);
    set(3'h0, 16'h0, 2'h0);
    chk("dly_off", dly, 1'b0);
    $display("test delay done");
    apb(1'b0, 8'h5c, 32'h0);
    chk("slverr", err, 1'b1);
    chk("unmapped", rd, 32'h0);
    apb(1'b1, 8'h18, 32'h0077);
    tick(2);
    chk("no_force", trip, 3'h0);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h18, 32'h0045);
    tick(2);
    chk("f_start", start, 3'h5);
    chk("f_trip", trip, 3'h4);
    rdc("f_stat", 8'h18, 32'h1045);
    tick(200);
    chk("f_end", start, 3'h0);
    apb(1'b0, 8'h3c, 32'h0);
    chk("f_irq", rd[9], 1'b1);
    apb(1'b1, 8'h48, 32'h1);
    rdc("fidx", 8'h58, 32'h0004_6400);
    $display("test force done");
    finish_test;
  end
endmodule
